// File: core/msx_pkg.sv
// Purpose: shared constants and types for the multiply/saturate/store slice
// Assumes: 32-bit data, 16 architectural registers
// Notes:   register map offsets are byte addresses on the register bus
package msx_pkg;
  // ********
  // widths and register numbers
  // ********
  localparam int        DW        = 32;
  localparam logic [3:0] REG_SP   = 4'hD;    // stack pointer number
  localparam logic [3:0] REG_PC   = 4'hF;    // program counter number
  localparam logic [4:0] SHAMT_ZERO = 5'h00;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // ********
  // bus register map
  // ********
  localparam logic [7:0] A_CTRL   = 8'h00;   // write: bit0 start
  localparam logic [7:0] A_INSTR  = 8'h04;   // instruction word
  localparam logic [7:0] A_OPA    = 8'h08;   // first source / base value
  localparam logic [7:0] A_OPB    = 8'h0C;   // second source value
  localparam logic [7:0] A_STAT   = 8'h10;   // status bits
  localparam logic [7:0] A_RES_LO = 8'h14;   // result low / single result
  localparam logic [7:0] A_RES_HI = 8'h18;   // result high
  localparam logic [7:0] A_ADDR   = 8'h1C;   // address / writeback value
  localparam logic [7:0] A_CNT    = 8'h20;   // words stored
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_Q    = 1;
  localparam int ST_UNDEF= 2;
  localparam int ST_UNPR = 3;
  localparam int ST_UFLT = 4;
  localparam int ST_WB   = 5;
  localparam int ST_COPROC_TWO_REG_MOVE = 6;
  // ********
  // operation classes
  // ********
  typedef enum logic [2:0] {
    MSX_OP_NONE, MSX_OP_MULL, MSX_OP_SAT, MSX_OP_CPST, MSX_OP_STM16, MSX_OP_STM32
  } msx_op_t;
  // memory write channel
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } msx_mem_t;
endpackage

// File: core/msx_core.sv
// Purpose: decode and execute slice: long multiply, saturate, coprocessor and multiple store
// Assumes: AXI4-Lite register access, memory accepts one word per mem_ready
// Notes:   register file lives outside; operands are handed in through the bus
//
// Notes on behaviour
// - long multiply writes 64-bit signed product halves
// - saturate clamps to field-plus-one signed width
// - saturation sets sticky flag, else unchanged
// - shift bit set, zero amount is undefined
// - shift type and amount decoded from fields
// - no shift means left shift by zero
// - saturated result sign-extended to 32 bits
// - register 13 or 15 operands unpredictable
// - unaccepted coprocessor store raises usage fault
// - offset is word_offset_field times four, added or subtracted
// - pre-index picks offset address; writeback updates base
// - coprocessor words stored four bytes apart until done
// - all-zero mode bits undefined; long only is move
// - coprocessor store base fifteen is unpredictable
// - long bit passed to coprocessor on cp_long
// - four-bit field picks one of sixteen coprocessors
// - offset multiple of four, zero to 1020
// - multiple store ascends from base, optional writeback
// - short form zero-extends list, always writes back
// - wide form clears bits 13, 15; checks base
// - wide writeback with base in list unpredictable
// - lowest register stored at lowest address
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module msx_core (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // register file reads for store multiple
  output      logic [3:0]          rf_rd_idx,
  input  wire logic [31:0]         rf_rd_data,
  // coprocessor side
  output      logic                cp_req,
  output      logic [3:0]          cp_num,
  output      logic                cp_long,
  output      logic [7:0]          cp_option,
  input  wire logic                cp_accept,
  input  wire logic                cp_reject,
  input  wire logic [31:0]         cp_word,
  input  wire logic                cp_done,
  output      logic                cp_word_taken,
  // memory side
  output      msx_pkg::msx_mem_t   mem_wr,
  input  wire logic                mem_ready,
  // fault event
  output      logic                usage_fault_a
);
  // ********
  // state and registers
  // ********
  typedef enum {S_IDLE, S_CPWAIT, S_CPXFER, S_STM} msx_st_t;
  msx_st_t      st_r;                 // sequencer state
  logic [31:0]  instr_r;              // captured instruction
  logic [31:0]  opa_r;                // first source or base value
  logic [31:0]  opb_r;                // second source value
  logic [31:0]  res_lo_r;             // low or single result
  logic [31:0]  res_hi_r;             // high result
  logic [31:0]  addr_r;               // running store address
  logic [31:0]  wb_r;                 // writeback value for base
  logic [15:0]  list_r;               // remaining store list
  logic [7:0]   cnt_r;                // words stored
  logic [6:0]   stat_r;               // status bits
  logic         start;                // software start strobe
  logic [1:0]   aw_ok_r;              // bit0 address held, bit1 data held
  logic [7:0]   awaddr_r;
  logic [31:0]  wdata_r;

  // ********
  // field decode
  // ********
  logic [15:0] hw1, hw2;
  assign hw1 = instr_r[31:16];        // first halfword
  assign hw2 = instr_r[15:0];         // second halfword
  logic [3:0] f_rn, f_rd, f_dest_high;
  assign f_rn   = hw1[3:0];
  assign f_rd   = hw2[11:8];
  assign f_dest_high = hw2[11:8];
  // operation class from opcode bits
  msx_pkg::msx_op_t op;
  always_comb begin
    if (instr_r[15:11] == 5'h18 && instr_r[31:16] == 16'h0000)
      op = msx_pkg::MSX_OP_STM16;
    else if (hw1[15:4] == 12'hFB8 && hw2[7:4] == 4'h0)
      op = msx_pkg::MSX_OP_MULL;
    else if (hw1[15:11] == 5'h1E && hw1[9:6] == 4'hC && hw1[4] == 1'b0)
      op = msx_pkg::MSX_OP_SAT;
    else if (hw1[15:13] == 3'h7 && hw1[11:9] == 3'h6 && hw1[4] == 1'b0)
      op = msx_pkg::MSX_OP_CPST;
    else if (hw1[15:6] == 10'h3A2 && hw1[4] == 1'b0)
      op = msx_pkg::MSX_OP_STM32;
    else
      op = msx_pkg::MSX_OP_NONE;
  end

  // long multiply
  logic signed [63:0] prod;
  assign prod = $signed(opa_r) * $signed(opb_r);

  // saturate: shift then clamp
  logic [4:0]  sat_amt;
  logic        sat_asr;
  logic [4:0]  sat_w1;                 // width minus one
  logic signed [31:0] shifted;
  logic signed [31:0] sat_hi, sat_lo;
  logic        sat_hit;
  logic [31:0] sat_res;
  assign sat_amt = {hw2[14:12], hw2[7:6]};
  assign sat_asr = hw1[5];                                    // shift type is hw1 bit 5
  assign sat_w1  = hw2[4:0];
  // zero amount with left shift is the no-shift form
  assign shifted = sat_asr ? ($signed(opa_r) >>> sat_amt)
                           : $signed(opa_r << sat_amt);
  assign sat_hi  = $signed((32'h0000_0001 << sat_w1) - 32'h0000_0001);
  assign sat_lo  = ~sat_hi;
  assign sat_hit = (shifted > sat_hi) || (shifted < sat_lo);
  // clamped value is already a sign-extended 32-bit word
  assign sat_res = (shifted > sat_hi) ? sat_hi :
                   (shifted < sat_lo) ? sat_lo : shifted;

  // coprocessor store fields
  logic cp_p, cp_u, cp_n, cp_w;
  logic [31:0] cp_imm, cp_off;
  assign {cp_p, cp_u, cp_n, cp_w} = hw1[8:5];
  assign cp_imm = {22'h0, hw2[7:0], 2'h0};
  assign cp_off = cp_u ? opa_r + cp_imm : opa_r - cp_imm;

  // store multiple list
  logic [15:0] stm_list;
  logic        stm_wb;
  logic [4:0]  stm_cnt;
  assign stm_list = (op == msx_pkg::MSX_OP_STM16) ? {8'h00, instr_r[7:0]}
                                                  : {1'b0, hw2[14], 1'b0, hw2[12:0]};
  assign stm_wb   = (op == msx_pkg::MSX_OP_STM16) ? 1'b1 : hw1[5];
  always_comb begin
    stm_cnt = 5'h00;
    for (int i = 0; i < 16; i++)
      stm_cnt = stm_cnt + {4'h0, stm_list[i]};
  end
  logic [3:0] stm_base;
  assign stm_base = (op == msx_pkg::MSX_OP_STM16) ? {1'b0, instr_r[10:8]} : f_rn;

  // lowest set bit of remaining list
  logic [3:0] low_idx;
  always_comb begin
    low_idx = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (list_r[i]) low_idx = 4'(i);
  end

  // ********
  // bus write path
  // ********
  assign s_axi_awready = ~aw_ok_r[0];
  assign s_axi_wready  = ~aw_ok_r[1];
  // address and data latch in either order, response after both
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_ok_r  <= 2'h0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r[0] <= 1'b1;
        awaddr_r   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        aw_ok_r[1] <= 1'b1;
        wdata_r    <= s_axi_wdata;
      end
      if (aw_ok_r == 2'h3 && !s_axi_bvalid)
        s_axi_bvalid <= 1'b1;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_ok_r      <= 2'h0;
      end
    end
  end
  logic wr_fire;
  assign wr_fire = (aw_ok_r == 2'h3) && !s_axi_bvalid;
  assign s_axi_bresp = msx_pkg::RESP_OK;
  assign start = wr_fire && awaddr_r == msx_pkg::A_CTRL && wdata_r[0] && st_r == S_IDLE;

  // operand registers, writable only while idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      instr_r <= 32'h0000_0000;
      opa_r   <= 32'h0000_0000;
      opb_r   <= 32'h0000_0000;
    end else if (wr_fire && st_r == S_IDLE) begin
      if (awaddr_r == msx_pkg::A_INSTR) instr_r <= wdata_r;
      if (awaddr_r == msx_pkg::A_OPA)   opa_r   <= wdata_r;
      if (awaddr_r == msx_pkg::A_OPB)   opb_r   <= wdata_r;
    end
  end

  // ********
  // bus read path
  // ********
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= msx_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= msx_pkg::RESP_OK;
      case (s_axi_araddr)
        msx_pkg::A_CTRL:   s_axi_rdata <= 32'h0000_0000;
        msx_pkg::A_INSTR:  s_axi_rdata <= instr_r;
        msx_pkg::A_OPA:    s_axi_rdata <= opa_r;
        msx_pkg::A_OPB:    s_axi_rdata <= opb_r;
        msx_pkg::A_STAT:   s_axi_rdata <= {25'h0, stat_r};
        msx_pkg::A_RES_LO: s_axi_rdata <= res_lo_r;
        msx_pkg::A_RES_HI: s_axi_rdata <= res_hi_r;
        msx_pkg::A_ADDR:   s_axi_rdata <= wb_r;
        msx_pkg::A_CNT:    s_axi_rdata <= {24'h0, cnt_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= msx_pkg::RESP_ERR;   // unmapped address
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ********
  // execute sequencer
  // ********
  logic mem_go;
  assign mem_go = mem_wr.valid && mem_ready;
  assign cp_word_taken = (st_r == S_CPXFER) && mem_go;
  assign cp_num    = hw2[11:8];
  assign cp_long   = cp_n;
  assign cp_option = hw2[7:0];
  assign cp_req    = (st_r == S_CPWAIT);
  assign rf_rd_idx = low_idx;

  // main sequence, results and status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r     <= S_IDLE;
      res_lo_r <= 32'h0000_0000;
      res_hi_r <= 32'h0000_0000;
      addr_r   <= 32'h0000_0000;
      wb_r     <= 32'h0000_0000;
      list_r   <= 16'h0000;
      cnt_r    <= 8'h00;
      stat_r   <= 7'h00;
      mem_wr   <= '0;
      usage_fault_a <= 1'b0;
    end else begin
      usage_fault_a <= 1'b0;
      // software clears the sticky flag by writing the status word with its bit set
      if (wr_fire && awaddr_r == msx_pkg::A_STAT && wdata_r[msx_pkg::ST_Q])
        stat_r[msx_pkg::ST_Q] <= 1'b0;
      case (st_r)
        S_IDLE: if (start) begin
          stat_r[msx_pkg::ST_COPROC_TWO_REG_MOVE:msx_pkg::ST_UNDEF] <= 5'h00;  // fresh outcome bits
          cnt_r <= 8'h00;
          case (op)
            msx_pkg::MSX_OP_MULL: begin
              res_hi_r <= prod[63:32];
              res_lo_r <= prod[31:0];
              stat_r[msx_pkg::ST_UNPR] <= (f_dest_high == hw2[15:12]);
            end
            msx_pkg::MSX_OP_SAT: begin
              if (sat_asr && sat_amt == msx_pkg::SHAMT_ZERO) begin
                stat_r[msx_pkg::ST_UNDEF] <= 1'b1;
              end else begin
                res_lo_r <= sat_res;
                if (sat_hit) stat_r[msx_pkg::ST_Q] <= 1'b1;
                stat_r[msx_pkg::ST_UNPR] <= f_rd == msx_pkg::REG_SP || f_rd == msx_pkg::REG_PC ||
                                            f_rn == msx_pkg::REG_SP || f_rn == msx_pkg::REG_PC;
              end
            end
            msx_pkg::MSX_OP_CPST: begin
              if (!cp_p && !cp_u && !cp_w) begin
                stat_r[msx_pkg::ST_UNDEF] <= !cp_n;
                stat_r[msx_pkg::ST_COPROC_TWO_REG_MOVE]  <= cp_n;
              end else begin
                stat_r[msx_pkg::ST_UNPR] <= (f_rn == msx_pkg::REG_PC);
                addr_r <= cp_p ? cp_off : opa_r;
                st_r   <= S_CPWAIT;
                stat_r[msx_pkg::ST_BUSY] <= 1'b1;
              end
            end
            msx_pkg::MSX_OP_STM16, msx_pkg::MSX_OP_STM32: begin
              stat_r[msx_pkg::ST_UNPR] <= (op == msx_pkg::MSX_OP_STM16) ? (stm_cnt == 5'h00)
                : (f_rn == msx_pkg::REG_PC || stm_cnt < 5'h02 ||
                   (stm_wb && stm_list[f_rn]));
              list_r <= stm_list;
              addr_r <= opa_r;
              wb_r   <= opa_r + {25'h0, stm_cnt, 2'h0};
              stat_r[msx_pkg::ST_WB] <= stm_wb;
              if (stm_cnt != 5'h00) begin
                st_r <= S_STM;
                stat_r[msx_pkg::ST_BUSY] <= 1'b1;
              end
            end
            default: stat_r[msx_pkg::ST_UNDEF] <= 1'b1;
          endcase
        end
        S_CPWAIT: begin
          if (cp_reject) begin
            usage_fault_a <= 1'b1;
            stat_r[msx_pkg::ST_UFLT] <= 1'b1;                 // base untouched
            stat_r[msx_pkg::ST_BUSY] <= 1'b0;
            st_r <= S_IDLE;
          end else if (cp_accept) begin
            wb_r <= cp_off;
            stat_r[msx_pkg::ST_WB] <= cp_w;
            mem_wr <= '{valid: 1'b1, addr: addr_r, data: cp_word};
            st_r <= S_CPXFER;
          end
        end
        // next word shows only after the taken pulse, so it is loaded a cycle later
        S_CPXFER: if (!mem_wr.valid) begin
          mem_wr.valid <= 1'b1;
          mem_wr.data  <= cp_word;
        end else if (mem_go) begin
          cnt_r <= cnt_r + 8'h01;
          mem_wr.valid <= 1'b0;
          if (cp_done) begin
            stat_r[msx_pkg::ST_BUSY] <= 1'b0;
            st_r <= S_IDLE;
          end else begin
            mem_wr.addr <= mem_wr.addr + msx_pkg::WORD_STEP;
          end
        end
        S_STM: begin
          if (!mem_wr.valid || mem_go) begin
            if (mem_go) cnt_r <= cnt_r + 8'h01;
            if (list_r != 16'h0000) begin
              mem_wr <= '{valid: 1'b1, addr: addr_r, data: rf_rd_data};
              addr_r <= addr_r + msx_pkg::WORD_STEP;
              list_r[low_idx] <= 1'b0;
            end else begin
              mem_wr.valid <= 1'b0;
              stat_r[msx_pkg::ST_BUSY] <= 1'b0;
              st_r <= S_IDLE;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ********
  // checks
  // ********
  a_undef_no_req: assert property (@(posedge ref_clk) disable iff (rst)
    cp_req |-> !stat_r[msx_pkg::ST_UNDEF])
    else $error("undefined store offered to coprocessor");
  a_xfer_step: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == S_CPXFER && mem_go && !cp_done) |=> mem_wr.addr == $past(mem_wr.addr) + 32'h4)
    else $error("store address did not step by one word");
  a_fault_no_mem: assert property (@(posedge ref_clk) disable iff (rst)
    usage_fault_a |-> !mem_wr.valid && !stat_r[msx_pkg::ST_WB])
    else $error("fault with memory activity or writeback");
  a_sat_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r == S_IDLE && start && op == msx_pkg::MSX_OP_SAT && !sat_asr && sat_hit)
    |=> stat_r[msx_pkg::ST_Q])
    else $error("saturation flag not set");
  a_mull_hi: assert property (@(posedge ref_clk) disable iff (rst)
    (start && op == msx_pkg::MSX_OP_MULL) |=> {res_hi_r, res_lo_r} == $past(prod))
    else $error("product halves wrong");
  a_sat_range: assert property (@(posedge ref_clk) disable iff (rst)
    (start && op == msx_pkg::MSX_OP_SAT && !(sat_asr && sat_amt == msx_pkg::SHAMT_ZERO))
    |=> $signed(res_lo_r) <= $past(sat_hi) && $signed(res_lo_r) >= $past(sat_lo))
    else $error("saturated result out of range");
  c_cp_store: cover property (@(posedge ref_clk) st_r == S_CPXFER && mem_go && cp_done);
  c_stm: cover property (@(posedge ref_clk) st_r == S_STM && list_r == 16'h0000);
  c_fault: cover property (@(posedge ref_clk) usage_fault_a);
endmodule

// File: sim/msx_far_model.sv
// Purpose: far-side model: coprocessor, memory and register file read port
// Assumes: one word per mem_ready; accept or refuse chosen by acc_en
// Notes:   memory stalls every other cycle; writes logged for the bench
`timescale 1ns/1ns
module msx_far_model (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [3:0]        rf_rd_idx,
  output      logic [31:0]       rf_rd_data,
  input  wire logic              cp_req,
  input  wire logic [3:0]        cp_num,
  input  wire logic              cp_long,
  input  wire logic [7:0]        cp_option,
  output      logic              cp_accept,
  output      logic              cp_reject,
  output      logic [31:0]       cp_word,
  output      logic              cp_done,
  input  wire logic              cp_word_taken,
  input  wire msx_pkg::msx_mem_t mem_wr,
  output      logic              mem_ready,
  input  wire logic              usage_fault_a,
  input  wire logic              acc_en,
  input  wire logic [3:0]        nwords
);
  logic [1:0]  wait_r;       // cycles cp_req has been held
  logic [3:0]  wi_r;         // index of the word on offer
  logic        act_r;        // transfer under way
  logic        tog_r;        // memory stall toggle
  logic        live;         // word on cp_word is meaningful
  logic [12:0] cp_seen;      // long, number and option at acceptance
  int          wr_cnt;       // memory writes seen
  int          uf_cnt;       // fault pulses seen
  logic [31:0] a_log [64];   // write addresses
  logic [31:0] d_log [64];   // write data
  // register file returns its own index in the low nibble
  assign rf_rd_data = {28'hA5A5000, rf_rd_idx};
  // answer after two cycles so the requester must really wait
  assign cp_accept  = cp_req & (wait_r == 2'h2) & acc_en;
  assign cp_reject  = cp_req & (wait_r == 2'h2) & ~acc_en;
  assign live       = act_r | cp_accept;
  // outside a transfer the word is inverted, never a stale copy
  assign cp_word    = live ? {28'hC0DE000, wi_r} : ~{28'hC0DE000, wi_r};
  assign cp_done    = live & (wi_r == nwords - 4'h1);
  assign mem_ready  = mem_wr.valid & tog_r;
  // ****************************************
  // coprocessor and memory state
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_r  <= 2'h0;
      wi_r    <= 4'h0;
      act_r   <= 1'h0;
      tog_r   <= 1'h0;
      cp_seen <= 13'h0;
      wr_cnt  <= 0;
      uf_cnt  <= 0;
    end else begin
      if (!cp_req) begin
        wait_r <= 2'h0;
      end else if (wait_r != 2'h2) begin
        wait_r <= wait_r + 2'h1;
      end
      if (cp_accept) begin
        act_r   <= 1'h1;
        cp_seen <= {cp_long, cp_num, cp_option};
      end else if (act_r && cp_word_taken) begin
        wi_r <= wi_r + 4'h1;
        if (cp_done) begin
          act_r <= 1'h0;
        end
      end else if (!act_r) begin
        wi_r <= 4'h0;
      end
      tog_r <= mem_wr.valid & ~tog_r;
      if (mem_ready) begin
        a_log[wr_cnt] <= mem_wr.addr;
        d_log[wr_cnt] <= mem_wr.data;
        wr_cnt        <= wr_cnt + 1;
      end
      if (usage_fault_a) begin
        uf_cnt <= uf_cnt + 1;
      end
    end
  end
endmodule

// File: sim/mul_sat_store_exec_slice_tb.sv
// Purpose: self-checking bench for msx_core
// Assumes: far-side model msx_far_model
// Notes:   register results read back over AXI4-Lite; memory writes checked from the model logs
`timescale 1ns/1ns
module mul_sat_store_exec_slice_tb;
  typedef struct packed {
    logic [31:0] i, a, b, lo;
    logic [5:0]  st, m;
    logic [1:0]  ck;
  } msx_tb_row_t;
  logic              ref_clk, rst, acc_en, cp_req, cp_long, cp_accept, cp_reject, cp_done, cp_word_taken;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, cp_option;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rf_rd_data, cp_word, rd;
  logic [3:0]        s_axi_wstrb, rf_rd_idx, cp_num, nwords;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_ready, usage_fault_a;
  msx_pkg::msx_mem_t mem_wr;
  logic [63:0]       prod;
  int                num_errors, samples_checked, n0, u0;
  msx_tb_row_t       rows [13];
  msx_core      dut (.*);
  msx_far_model part (.*);
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail_wait;
    num_errors++;
    end_of_test();
  endtask
  // handshakes are sampled at the rising edge, each channel released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n <= 200; n++) begin
      @(posedge ref_clk);
      if (n == 200) fail_wait();
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n <= 200; n++) begin
      @(posedge ref_clk);
      if (n == 200) fail_wait();
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        {rd, rr} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask
  // load operands, start, then poll busy; rd ends holding status
  task automatic run(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b);
    axi_wr(msx_pkg::A_OPA, a);
    axi_wr(msx_pkg::A_OPB, b);
    axi_wr(msx_pkg::A_INSTR, i);
    axi_wr(msx_pkg::A_CTRL, 32'h1);
    for (int n = 0; n < 60; n++) begin
      axi_rd(msx_pkg::A_STAT);
      if (rd[msx_pkg::ST_BUSY] === 1'h0) break;
      if (n == 59) fail_wait();
    end
  endtask
  task automatic stm_chk(input logic [31:0] base, input logic [14:0] l);
    int j;
    j = 0;
    for (int k = 0; k < 15; k++) begin
      if (l[k]) begin
        chk("stm_addr", part.a_log[n0 + j], base + 32'(4 * j));
        chk("stm_data", part.d_log[n0 + j], {28'hA5A5000, 4'(k)});
        j++;
      end
    end
    chk("stm_count", 32'(part.wr_cnt - n0), 32'(j));
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, acc_en, nwords, s_axi_wstrb} = {1'h1, 1'h1, 4'h1, 4'hF};
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, num_errors, samples_checked} = '0;
    rows = '{'{32'hFB831204, 32'hFFFFFFFD, 32'h7, 32'h0, 6'h0, 6'h3F, 2'h2},
             '{32'hFB831204, 32'h80000000, 32'h80000000, 32'h0, 6'h0, 6'h3F, 2'h2},
             '{32'hF302111F, 32'h12, 32'h0, 32'h120, 6'h0, 6'h3F, 2'h1},
             '{32'hF32271C0, 32'h80000000, 32'h0, 32'hFFFFFFFF, 6'h0, 6'h3F, 2'h1},
             '{32'hF3020107, 32'h100, 32'h0, 32'h7F, 6'h1, 6'h3F, 2'h1},
             '{32'hF3020107, 32'hFFFFFF00, 32'h0, 32'hFFFFFF80, 6'h1, 6'h3F, 2'h1},
             '{32'hF3220107, 32'h0, 32'h0, 32'h0, 6'h3, 6'h3F, 2'h0},
             '{32'hF3020D07, 32'h5, 32'h0, 32'h5, 6'h5, 6'h3F, 2'h1},
             '{32'hEC020510, 32'h1000, 32'h0, 32'h0, 6'h3, 6'h3F, 2'h0},
             '{32'hEC420510, 32'h1000, 32'h0, 32'h0, 6'h21, 6'h3F, 2'h0},
             '{32'hED6F0510, 32'h1000, 32'h0, 32'h0, 6'h4, 6'h4, 2'h0},
             '{32'h0000C200, 32'h3000, 32'h0, 32'h0, 6'h4, 6'h4, 2'h0},
             '{32'hE8A14003, 32'h3000, 32'h0, 32'h0, 6'h4, 6'h4, 2'h0}};
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    axi_rd(msx_pkg::A_STAT);
    chk("stat_reset", rd, 32'h0);
    chk("idle_outputs", {30'h0, cp_req, mem_wr.valid}, 32'h0);
    axi_rd(8'h40);
    chk("unmapped_resp", {30'h0, rr}, {30'h0, msx_pkg::RESP_ERR});
    $display("reset test done");
    // ordinary cases: status mask, then results where defined
    for (int k = 0; k < 13; k++) begin
      run(rows[k].i, rows[k].a, rows[k].b);
      chk("status", {26'h0, rd[6:1] & rows[k].m}, {26'h0, rows[k].st});
      prod = $signed(rows[k].a) * $signed(rows[k].b);
      if (rows[k].ck == 2'h2) begin
        axi_rd(msx_pkg::A_RES_LO);
        chk("product_low", rd, prod[31:0]);
        axi_rd(msx_pkg::A_RES_HI);
        chk("product_high", rd, prod[63:32]);
      end
      if (rows[k].ck == 2'h1) begin
        axi_rd(msx_pkg::A_RES_LO);
        chk("saturated", rd, rows[k].lo);
      end
      $display("row %0d done", k);
    end
    // sticky flag cleared, then a non-clamping saturate leaves it clear
    axi_wr(msx_pkg::A_STAT, 32'h2);
    run(32'hF302111F, 32'h12, 32'h0);
    chk("sticky_clear", {31'h0, rd[msx_pkg::ST_Q]}, 32'h0);
    $display("sticky test done");
    // pre-indexed subtract with writeback, three words with stalls
    nwords <= 4'h3;
    n0 = part.wr_cnt;
    run(32'hED620510, 32'h1000, 32'h0);
    chk("cp_flags", {26'h0, rd[6:1]}, 32'h10);
    for (int j = 0; j < 3; j++) begin
      chk("cp_addr", part.a_log[n0 + j], 32'h0FC0 + 32'(4 * j));
      chk("cp_data", part.d_log[n0 + j], {28'hC0DE000, 4'(j)});
    end
    chk("cp_count", 32'(part.wr_cnt - n0), 32'h3);
    chk("cp_request", {19'h0, part.cp_seen}, {19'h0, 1'h1, 4'h5, 8'h10});
    axi_rd(msx_pkg::A_ADDR);
    chk("cp_writeback", rd, 32'h0FC0);
    $display("coprocessor store test done");
    // refused store: one fault pulse, no memory traffic, no writeback
    acc_en <= 1'h0;
    n0 = part.wr_cnt;
    u0 = part.uf_cnt;
    run(32'hED620910, 32'h1000, 32'h0);
    chk("fault_flags", {26'h0, rd[6:1]}, 32'h08);
    chk("fault_pulses", 32'(part.uf_cnt - u0), 32'h1);
    chk("fault_writes", 32'(part.wr_cnt - n0), 32'h0);
    acc_en <= 1'h1;
    $display("refused store test done");
    // short form: registers 0, 2, 5, 7 from base 0x3000
    n0 = part.wr_cnt;
    run(32'h0000C2A5, 32'h3000, 32'h0);
    chk("stm_flags", {26'h0, rd[6:1]}, 32'h10);
    stm_chk(32'h3000, 15'h00A5);
    axi_rd(msx_pkg::A_ADDR);
    chk("stm_writeback", rd, 32'h3010);
    // wide form with bits 13 and 15 set: they must be ignored
    n0 = part.wr_cnt;
    run(32'hE8A2E003, 32'h4000, 32'h0);
    stm_chk(32'h4000, 15'h4003);
    axi_rd(msx_pkg::A_ADDR);
    chk("wide_writeback", rd, 32'h400C);
    $display("store multiple test done");
    end_of_test();
  end
endmodule
